/* File: include/imc_pkg.sv */
package imc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int SS_HALF_NS = 5000;
  localparam int FS_HALF_NS = 1250;
  localparam logic [8:0] SS_HALF = 9'((SS_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [8:0] FS_HALF = 9'((FS_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TAR = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_HOLD = 8'h10;
  localparam logic [7:0] A_RAW = 8'h14;
  localparam logic [7:0] A_MASK = 8'h18;
  localparam logic [7:0] A_MSTAT = 8'h1C;
  localparam logic [7:0] A_OWN = 8'h20;
  localparam logic [7:0] A_DMA = 8'h24;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [9:0] TAR_RST = 10'h000;
  localparam logic [9:0] OWN_RST = 10'h055;
  localparam logic [7:0] HOLD_RST = 8'h0A;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] DMA_RST = 2'h0;
  localparam int C_EN = 0;
  localparam int C_FAST = 1;
  localparam int C_RSTEN = 2;
  localparam int C_A10 = 3;
  localparam int NEV = 4;
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_ARB = 2;
  localparam int EV_NACK = 3;
  localparam logic [4:0] HDR10 = 5'h1E;
  localparam logic [5:0] DMA_TX_LVL = 6'h04;
  typedef enum logic [2:0] {
    IMC_IDLE = 3'h0,
    IMC_START = 3'h1,
    IMC_LOW = 3'h2,
    IMC_HIGH = 3'h3,
    IMC_STOP1 = 3'h4,
    IMC_STOP2 = 3'h5,
    IMC_RST1 = 3'h6,
    IMC_RST2 = 3'h7
  } imc_state_t;
endpackage

/* File: rtl/imc_master.sv */
`timescale 1ns/1ps
module imc_master #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  function automatic logic is_at(input logic [7:0] a, input logic [7:0] o);
    is_at = (a == o);
  endfunction

  logic acc, wr_en, rd_en, map_ok;
  logic [31:0] next_prdata;
  logic [3:0] ctrl, raw, mask, ev, ev_set;
  logic [9:0] tar, own;
  logic [7:0] hold;
  logic [1:0] dma_en;
  logic [8:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [AW:0] tx_cnt, rx_cnt;
  logic tx_push, tx_pop, tx_flush, rx_push, rx_pop;
  logic [8:0] tx_head, tx_next;
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic start_ev, stop_ev, bus_busy, bus_free;
  logic [8:0] idle_cnt, half, hold_eff, cnt;
  imc_pkg::imc_state_t state;
  logic [3:0] bitn;
  logic [7:0] tx_sh, rx_sh;
  logic rd, in_addr, cur_dir, last_rd, a10, arb_p, nack_p, bit_out, stall;
  logic hi_end, done_data;
  logic [1:0] astep;
  logic [9:0] tar_l;

  // apb slave, one wait state
  assign acc = psel & penable & pready;
  assign wr_en = acc & pwrite;
  assign rd_en = acc & ~pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  always_comb
  begin
    next_prdata = 32'h0;
    map_ok = 1'b1;
    case (paddr)
      imc_pkg::A_CTRL: next_prdata = {28'h0, ctrl};
      imc_pkg::A_TAR: next_prdata = {22'h0, tar};
      imc_pkg::A_DATA: next_prdata = {24'h0, rx_cnt != 0 ? rx_mem[rx_rp] : 8'h00};
      imc_pkg::A_STAT: next_prdata = {14'h0, bus_busy, state != imc_pkg::IMC_IDLE,
                                      2'h0, 6'(rx_cnt), 2'h0, 6'(tx_cnt)};
      imc_pkg::A_HOLD: next_prdata = {24'h0, hold};
      imc_pkg::A_RAW: next_prdata = {28'h0, raw};
      imc_pkg::A_MASK: next_prdata = {28'h0, mask};
      imc_pkg::A_MSTAT: next_prdata = {28'h0, raw & mask};
      imc_pkg::A_OWN: next_prdata = {22'h0, own};
      imc_pkg::A_DMA: next_prdata = {30'h0, dma_en};
      default: map_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      prdata <= pwrite ? 32'h0 : next_prdata;
      pslverr <= ~map_ok;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= imc_pkg::CTRL_RST;
      tar <= imc_pkg::TAR_RST;
      hold <= imc_pkg::HOLD_RST;
      mask <= imc_pkg::MASK_RST;
      own <= imc_pkg::OWN_RST;
      dma_en <= imc_pkg::DMA_RST;
    end
    else if (wr_en)
    begin
      if (is_at(paddr, imc_pkg::A_CTRL))
        ctrl <= pwdata[3:0];
      if (is_at(paddr, imc_pkg::A_TAR))
        tar <= pwdata[9:0];
      if (is_at(paddr, imc_pkg::A_HOLD))
        hold <= pwdata[7:0];
      if (is_at(paddr, imc_pkg::A_MASK))
        mask <= pwdata[3:0];
      if (is_at(paddr, imc_pkg::A_OWN))
        own <= pwdata[9:0];
      if (is_at(paddr, imc_pkg::A_DMA))
        dma_en <= pwdata[1:0];
    end
  end

  // raw status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      raw <= 4'h0;
    else if (wr_en && is_at(paddr, imc_pkg::A_RAW))
      raw <= (raw & ~pwdata[3:0]) | ev_set;
    else
      raw <= raw | ev_set;
  end

  // event crossing from engine side
  assign ev = {nack_p, arb_p, stop_ev, start_ev};
  generate
    for (genvar i = 0; i < imc_pkg::NEV; i++)
    begin : g_ev
      logic tgl, syn_m, syn_s, syn_p;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tgl <= 1'b0;
          syn_m <= 1'b0;
          syn_s <= 1'b0;
          syn_p <= 1'b0;
        end
        else
        begin
          tgl <= tgl ^ ev[i];
          syn_m <= tgl;
          syn_s <= syn_m;
          syn_p <= syn_s;
        end
      end
      assign ev_set[i] = syn_s ^ syn_p;
    end
  endgenerate

  // tx fifo: {read flag, data}
  assign tx_push = wr_en && is_at(paddr, imc_pkg::A_DATA) && tx_cnt != FULL;
  assign tx_head = tx_mem[tx_rp];
  assign tx_next = tx_mem[tx_rp + 1'b1];

  always_ff @(posedge pclk)
  begin
    if (tx_push)
      tx_mem[tx_wp] <= pwdata[8:0];
    if (rx_push)
      rx_mem[rx_wp] <= rx_sh;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end
    else if (tx_flush)
    begin
      tx_rp <= tx_wp;
      tx_cnt <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp <= tx_wp + 1'b1;
      if (tx_pop)
        tx_rp <= tx_rp + 1'b1;
      tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  assign rx_pop = rd_en && is_at(paddr, imc_pkg::A_DATA) && rx_cnt != 0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end
    else
    begin
      if (rx_push)
        rx_wp <= rx_wp + 1'b1;
      if (rx_pop)
        rx_rp <= rx_rp + 1'b1;
      rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // dma requests
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
    end
    else
    begin
      dma_tx_req <= dma_en[0] && 6'(tx_cnt) <= imc_pkg::DMA_TX_LVL;
      dma_rx_req <= dma_en[1] && rx_cnt != 0;
    end
  end

  // line synchronisers and event filter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
  assign half = ctrl[imc_pkg::C_FAST] ? imc_pkg::FS_HALF : imc_pkg::SS_HALF;
  assign hold_eff = ({1'b0, hold} > half - 9'h002) ? half - 9'h002 : {1'b0, hold};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_busy <= 1'b0;
      idle_cnt <= 9'h000;
      bus_free <= 1'b0;
    end
    else
    begin
      if (start_ev)
        bus_busy <= 1'b1;
      else if (stop_ev)
        bus_busy <= 1'b0;
      if (!(scl_s && sda_s) || bus_busy || start_ev)
        idle_cnt <= 9'h000;
      else if (idle_cnt != half)
        idle_cnt <= idle_cnt + 9'h001;
      bus_free <= idle_cnt == half;
    end
  end

  // bit engine
  assign bit_out = (bitn == 4'h8) ? (rd ? last_rd : 1'b1) : (rd | tx_sh[7]);
  assign stall = rd && bitn == 4'h0 && rx_cnt == FULL;
  assign hi_end = state == imc_pkg::IMC_HIGH && scl_s && cnt == half - 9'h001;
  assign done_data = hi_end && bitn == 4'h8 && !in_addr && (rd || !sda_s);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= imc_pkg::IMC_IDLE;
      cnt <= 9'h000;
      bitn <= 4'h0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      {rd, in_addr, cur_dir, last_rd, a10} <= 5'h00;
      {arb_p, nack_p, tx_pop, tx_flush, rx_push} <= 5'h00;
      astep <= 2'h0;
      tar_l <= 10'h000;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      {arb_p, nack_p, tx_pop, tx_flush, rx_push} <= 5'h00;
      unique case (state)
        imc_pkg::IMC_IDLE:
        begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          cnt <= 9'h000;
          if (ctrl[imc_pkg::C_EN] && tx_cnt != 0 && bus_free)
          begin
            state <= imc_pkg::IMC_START;
            sda_oe <= 1'b1;
            a10 <= ctrl[imc_pkg::C_A10];
            tar_l <= tar;
            astep <= 2'h0;
          end
        end
        imc_pkg::IMC_START:
        begin
          cnt <= cnt + 9'h001;
          if (cnt == half - 9'h001)
          begin
            scl_oe <= 1'b1;
            cnt <= 9'h000;
            bitn <= 4'h0;
            rd <= 1'b0;
            in_addr <= 1'b1;
            cur_dir <= tx_head[8];
            if (a10)
              tx_sh <= {imc_pkg::HDR10, tar_l[9:8], astep == 2'h2};
            else
              tx_sh <= {tar_l[6:0], tx_head[8]};
            state <= imc_pkg::IMC_LOW;
          end
        end
        imc_pkg::IMC_LOW:
        begin
          if (cnt == hold_eff)
            sda_oe <= ~bit_out;
          if (cnt != half - 9'h001)
            cnt <= cnt + 9'h001;
          else if (!stall)
          begin
            scl_oe <= 1'b0;
            cnt <= 9'h000;
            state <= imc_pkg::IMC_HIGH;
          end
        end
        imc_pkg::IMC_HIGH:
        begin
          if (scl_s)
            cnt <= cnt + 9'h001;
          if (scl_s && !sda_oe && !sda_s && !rd && bitn != 4'h8)
          begin
            sda_oe <= 1'b0;
            arb_p <= 1'b1;
            state <= imc_pkg::IMC_IDLE;
          end
          else if (hi_end)
          begin
            cnt <= 9'h000;
            scl_oe <= 1'b1;
            state <= imc_pkg::IMC_LOW;
            if (bitn != 4'h8)
            begin
              rx_sh <= {rx_sh[6:0], sda_s};
              tx_sh <= {tx_sh[6:0], 1'b0};
              bitn <= bitn + 4'h1;
            end
            else
            begin
              bitn <= 4'h0;
              if (!rd && sda_s)
              begin
                nack_p <= 1'b1;
                tx_flush <= 1'b1;
                state <= imc_pkg::IMC_STOP1;
              end
              else if (in_addr && a10 && astep == 2'h0)
              begin
                tx_sh <= tar_l[7:0];
                astep <= 2'h1;
              end
              else if (in_addr && a10 && astep == 2'h1 && cur_dir)
              begin
                astep <= 2'h2;
                state <= imc_pkg::IMC_RST1;
              end
              else if (!in_addr && tx_cnt == 0)
                state <= imc_pkg::IMC_STOP1;
              else if (!in_addr && tx_head[8] != cur_dir)
              begin
                astep <= 2'h0;
                if (ctrl[imc_pkg::C_RSTEN])
                  state <= imc_pkg::IMC_RST1;
                else
                  state <= imc_pkg::IMC_STOP1;
              end
              else
              begin
                in_addr <= 1'b0;
                tx_pop <= 1'b1;
                rd <= tx_head[8];
                tx_sh <= tx_head[7:0];
                last_rd <= tx_cnt == 1 || tx_next[8] != tx_head[8];
              end
              if (rd)
                rx_push <= 1'b1;
            end
          end
        end
        imc_pkg::IMC_STOP1:
        begin
          cnt <= cnt + 9'h001;
          if (cnt == hold_eff)
            sda_oe <= 1'b1;
          if (cnt == half - 9'h001)
          begin
            scl_oe <= 1'b0;
            cnt <= 9'h000;
            state <= imc_pkg::IMC_STOP2;
          end
        end
        imc_pkg::IMC_STOP2:
        begin
          if (scl_s)
            cnt <= cnt + 9'h001;
          if (hi_end || (scl_s && cnt == half - 9'h001))
          begin
            sda_oe <= 1'b0;
            state <= imc_pkg::IMC_IDLE;
          end
        end
        imc_pkg::IMC_RST1:
        begin
          cnt <= cnt + 9'h001;
          if (cnt == hold_eff)
            sda_oe <= 1'b0;
          if (cnt == half - 9'h001)
          begin
            scl_oe <= 1'b0;
            cnt <= 9'h000;
            state <= imc_pkg::IMC_RST2;
          end
        end
        imc_pkg::IMC_RST2:
        begin
          if (scl_s)
            cnt <= cnt + 9'h001;
          if (scl_s && cnt == half - 9'h001)
          begin
            cnt <= 9'h000;
            sda_oe <= 1'b1;
            state <= imc_pkg::IMC_START;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  property p_open_drain;
    @(posedge pclk) disable iff (!presetn) !scl_o && !sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  property p_sda_stable;
    @(posedge pclk) disable iff (!presetn)
      (state == imc_pkg::IMC_HIGH && $past(state) == imc_pkg::IMC_HIGH) |-> $stable(sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("sda moved in high");

  property p_start_cond;
    @(posedge pclk) disable iff (!presetn)
      (state == imc_pkg::IMC_START && $past(state) == imc_pkg::IMC_START) |-> sda_oe && !scl_oe;
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("bad start");

  property p_idle_gate;
    @(posedge pclk) disable iff (!presetn)
      ($past(state) == imc_pkg::IMC_IDLE && state == imc_pkg::IMC_START) |-> $past(bus_free);
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("start on busy bus");

  property p_tx_start;
    @(posedge pclk) disable iff (!presetn)
      ($past(state) == imc_pkg::IMC_IDLE && state == imc_pkg::IMC_START) |-> $past(tx_cnt) != 0;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start without data");

  property p_empty_stop;
    @(posedge pclk) disable iff (!presetn)
      (done_data && tx_cnt == 0) |=> state == imc_pkg::IMC_STOP1;
  endproperty
  a_empty_stop: assert property (p_empty_stop) else $error("no stop on empty");

  property p_arb;
    @(posedge pclk) disable iff (!presetn)
      arb_p |-> !sda_oe && state == imc_pkg::IMC_IDLE;
  endproperty
  a_arb: assert property (p_arb) else $error("sda kept after loss");

  property p_toggle;
    @(posedge pclk) disable iff (!presetn) nack_p |-> ##4 raw[imc_pkg::EV_NACK];
  endproperty
  a_toggle: assert property (p_toggle) else $error("event not crossed");

  property p_nack_last;
    @(posedge pclk) disable iff (!presetn)
      (state == imc_pkg::IMC_LOW && rd && bitn == 4'h8 && last_rd && cnt > hold_eff)
      |-> !sda_oe;
  endproperty
  a_nack_last: assert property (p_nack_last) else $error("last byte acked");
endmodule

/* File: bench/imc_slave_model.sv */
`timescale 1ns/1ps
module imc_slave_model #(
  parameter logic [6:0] ADDR = 7'h3C
) (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  logic ps = 1'h1;
  logic pd = 1'h1;
  logic first = 1'h0;
  logic rd = 1'h0;
  logic act = 1'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] txb = 8'hA5;
  logic [7:0] log_q[$];
  logic mack_q[$];
  int cnt = 0;
  int starts = 0;
  int stops = 0;
  int per = 0;
  int tper = 0;
  initial pull = 1'h0;
  // open drain: only pulls low or lets go
  always @(posedge pclk)
  begin
    tper++;
    if (ps && pd && scl && !sda)
    begin
      starts++;
      cnt = 0;
      first = 1'h1;
      rd = 1'h0;
      pull <= 1'h0;
    end
    else if (ps && !pd && scl && sda)
    begin
      stops++;
      rd = 1'h0;
      pull <= 1'h0;
    end
    else if (!ps && scl)
    begin
      if (cnt == 3) per = tper;
      tper = 0;
      if (cnt < 8) sh = {sh[6:0], sda};
      if (cnt == 7) log_q.push_back(sh);
      if (cnt == 8 && rd)
      begin
        mack_q.push_back(sda);
        rd = !sda;
        txb = txb + 8'h01;
      end
      cnt++;
    end
    else if (ps && !scl)
    begin
      if (cnt == 8) pull <= !rd && (first ? sh[7:1] == ADDR : act);
      else if (cnt == 9)
      begin
        cnt = 0;
        if (first) act = sh[7:1] == ADDR;
        if (first) rd = act && sh[0];
        first = 1'h0;
        pull <= rd && !txb[7];
      end
      else if (rd && cnt > 0 && cnt < 8) pull <= !txb[7 - cnt];
    end
    ps = scl;
    pd = sda;
  end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic scl_o, scl_oe, sda_o, sda_oe, dma_tx_req, dma_rx_req, s_pull, scl_w, sda_w, rival;
  int err_total, comparisons, k, s0, t0;
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || s_pull || rival);
  imc_master i_imc_master (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req)
  );
  imc_slave_model i_imc_slave_model (.pclk(pclk), .scl(scl_w), .sda(sda_w), .pull(s_pull));
  initial
  begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (n == 50) err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, rd)
  endtask
  task automatic log_is(input logic [7:0] e);
    logic [7:0] g;
    g = 'x;
    if (i_imc_slave_model.log_q.size() > 0) g = i_imc_slave_model.log_q.pop_front();
    `CHK("wire byte", e, g)
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      apb(1'h0, imc_pkg::A_STAT, 32'h0);
      n++;
    end
    while ((rd[17:16] !== 2'h0 || rd[5:0] !== 6'h0) && n < 30000);
    if (n == 30000) err_total++;
    repeat (20) @(posedge pclk);
  endtask
  initial
  begin
    #1500000;
    err_total++;
    complete_run();
  end
  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rival = 1'h0;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    // reset values and unmapped access
    chk_rd(imc_pkg::A_CTRL, 32'h0);
    chk_rd(imc_pkg::A_TAR, 32'h0);
    chk_rd(imc_pkg::A_HOLD, 32'h0000000A);
    chk_rd(imc_pkg::A_OWN, 32'h00000055);
    chk_rd(imc_pkg::A_MASK, 32'h0);
    chk_rd(imc_pkg::A_DMA, 32'h0);
    chk_rd(imc_pkg::A_STAT, 32'h0);
    apb(1'h0, 8'h28, 32'h0);
    `CHK("unmapped err", 1'h1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'h1, imc_pkg::A_HOLD, 32'h00000020);
    chk_rd(imc_pkg::A_HOLD, 32'h00000020);
    // standard speed write of two bytes
    apb(1'h1, imc_pkg::A_TAR, 32'h0000003C);
    apb(1'h1, imc_pkg::A_CTRL, 32'h1);
    apb(1'h1, imc_pkg::A_DATA, 32'h0000005A);
    apb(1'h1, imc_pkg::A_DATA, 32'h000000C3);
    wait_idle();
    log_is(8'h78);
    log_is(8'h5A);
    log_is(8'hC3);
    `CHK("starts", 1, i_imc_slave_model.starts)
    `CHK("stops", 1, i_imc_slave_model.stops)
    `CHK("std period", 1'h1, i_imc_slave_model.per >= 400 && i_imc_slave_model.per < 440)
    chk_rd(imc_pkg::A_RAW, 32'h3);
    chk_rd(imc_pkg::A_MSTAT, 32'h0);
    apb(1'h1, imc_pkg::A_MASK, 32'h2);
    chk_rd(imc_pkg::A_MSTAT, 32'h2);
    apb(1'h1, imc_pkg::A_RAW, 32'h3);
    chk_rd(imc_pkg::A_RAW, 32'h0);
    // write then read, with and without restart
    for (k = 0; k < 2; k++)
    begin
      s0 = i_imc_slave_model.starts;
      t0 = i_imc_slave_model.stops;
      ex = 32'h000000A5 + 32'(2 * k);
      apb(1'h1, imc_pkg::A_CTRL, (k == 0) ? 32'h7 : 32'h3);
      apb(1'h1, imc_pkg::A_DATA, 32'h00000011);
      apb(1'h1, imc_pkg::A_DATA, 32'h00000100);
      apb(1'h1, imc_pkg::A_DATA, 32'h00000100);
      wait_idle();
      log_is(8'h78);
      log_is(8'h11);
      log_is(8'h79);
      log_is(ex[7:0]);
      log_is(ex[7:0] + 8'h01);
      `CHK("acks", 2'h1, {i_imc_slave_model.mack_q[0], i_imc_slave_model.mack_q[1]})
      i_imc_slave_model.mack_q.delete();
      `CHK("starts", 2, i_imc_slave_model.starts - s0)
      `CHK("stops", (k == 0) ? 1 : 2, i_imc_slave_model.stops - t0)
      chk_rd(imc_pkg::A_DATA, ex);
      chk_rd(imc_pkg::A_DATA, ex + 32'h1);
      chk_rd(imc_pkg::A_DATA, 32'h0);
    end
    `CHK("fast period", 1'h1, i_imc_slave_model.per >= 100 && i_imc_slave_model.per < 110)
    // no answer from the target
    apb(1'h1, imc_pkg::A_RAW, 32'hF);
    apb(1'h1, imc_pkg::A_TAR, 32'h00000022);
    apb(1'h1, imc_pkg::A_DATA, 32'h00000033);
    apb(1'h1, imc_pkg::A_DATA, 32'h00000044);
    wait_idle();
    log_is(8'h44);
    `CHK("bytes after nack", 0, i_imc_slave_model.log_q.size())
    chk_rd(imc_pkg::A_RAW, 32'hB);
    // competing master holds sda low during our address
    apb(1'h1, imc_pkg::A_RAW, 32'hF);
    apb(1'h1, imc_pkg::A_DATA, 32'h00000066);
    do
      apb(1'h0, imc_pkg::A_STAT, 32'h0);
    while (rd[16] !== 1'h1);
    rival <= 1'h1;
    repeat (600) @(posedge pclk);
    `CHK("arb release", 2'h0, {scl_oe, sda_oe})
    chk_rd(imc_pkg::A_RAW, 32'h5);
    rival <= 1'h0;
    wait_idle();
    log_is(8'h44);
    // ten bit header
    apb(1'h1, imc_pkg::A_CTRL, 32'hB);
    apb(1'h1, imc_pkg::A_TAR, 32'h000002B5);
    apb(1'h1, imc_pkg::A_DATA, 32'h00000055);
    wait_idle();
    log_is(8'hF4);
    // fifo fill and dma requests
    apb(1'h1, imc_pkg::A_CTRL, 32'h0);
    apb(1'h1, imc_pkg::A_TAR, 32'h00000022);
    apb(1'h1, imc_pkg::A_DMA, 32'h3);
    chk_rd(imc_pkg::A_DMA, 32'h3);
    `CHK("dma tx", 1'h1, dma_tx_req)
    `CHK("dma rx", 1'h0, dma_rx_req)
    s0 = i_imc_slave_model.starts;
    for (k = 0; k < 33; k++) apb(1'h1, imc_pkg::A_DATA, 32'(k));
    chk_rd(imc_pkg::A_STAT, 32'h00000020);
    `CHK("dma tx full", 1'h0, dma_tx_req)
    `CHK("no start when off", s0, i_imc_slave_model.starts)
    apb(1'h1, imc_pkg::A_CTRL, 32'h3);
    wait_idle();
    chk_rd(imc_pkg::A_STAT, 32'h0);
    `CHK("dma tx empty", 1'h1, dma_tx_req)
    `CHK("drive levels", 2'h0, {scl_o, sda_o})
    // single byte read with dma receive request
    apb(1'h1, imc_pkg::A_TAR, 32'h0000003C);
    apb(1'h1, imc_pkg::A_DATA, 32'h00000100);
    wait_idle();
    `CHK("dma rx", 1'h1, dma_rx_req)
    chk_rd(imc_pkg::A_DATA, 32'h000000A9);
    repeat (2) @(posedge pclk);
    `CHK("dma rx empty", 1'h0, dma_rx_req)
    complete_run();
  end
endmodule
